//--- pkg/spi_port_map.svh
// Register map, field positions, reset values and divider counts of the serial port.
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
`define PORT_CONTROL_IDX        8'h10
`define PORT_STATUS_CONTROL_IDX 8'h11
`define PORT_DATA_IDX           8'h12
`define CTL_RX_IE               7
`define CTL_MASTER_SELECT       5
`define CTL_CPOL                4
`define CTL_CPHA                3
`define CTL_WIRED_OR_MODE       2
`define CTL_MODULE_ENABLE       1
`define CTL_TX_IE               0
`define ST_RX_FULL              7
`define ST_ERR_IE               6
`define ST_OVERFLOW             5
`define ST_MODE_FAULT           4
`define ST_TX_EMPTY             3
`define ST_FAULT_DETECT_ENABLE  2
`define ST_RATE_HI              1
`define ST_RATE_LO              0
`define ST_WRITE_MASK           8'h47
`define CTL_RESET               8'h28
`define ST_RESET                8'h08
`define HALF_DIV0               5'h00
`define HALF_DIV1               5'h03
`define HALF_DIV2               5'h07
`define HALF_DIV3               5'h0F
`define EDGE_LAST               5'h0F
`define PIN_MOSI                0
`define PIN_SCLK                1
`define PIN_SS                  2
`endif

//--- pkg/spi_port_pkg.sv
// Types shared by the serial port design.
`default_nettype none
package spi_port_pkg;
    typedef enum logic {
        XFER_IDLE,
        XFER_RUN
    } xfer_e;
    typedef logic [7:0] byte_t;
    typedef struct packed {
        byte_t      ctrl;
        byte_t      stat;
        byte_t      txbuf;
        byte_t      shreg;
        byte_t      rxbuf;
        byte_t      prdata;
        logic       pslverr;
        logic       txfull;
        xfer_e      state;
        logic [4:0] ecnt;
        logic [4:0] div;
        logic       sclk_out;
        logic       dout;
        logic [2:0] sclk_sync;
        logic [2:0] ss_sync;
        logic [1:0] mosi_sync;
        logic [1:0] miso_sync;
        logic       fault_arm;
        logic       ovr_arm;
        logic [3:0] lead_cnt;
    } state_s;
endpackage
`default_nettype wire

//--- rtl/spi_port.sv
// Serial port: APB registers, master and slave byte engine, pin ownership and break protection.
//
// How it works
// - Break clear enable lets accesses during break clear status bits normally.
// - A flag cleared during break stays cleared after break ends.
// - Without break clear enable, break accesses leave flags; two-step clears finish later.
// - Data write during protected break is dropped: no load, no transfer.
// - Four pins: data in, data out, serial clock, select; three shared.
// - Wired-OR mode makes the data-out pin open drain.
// - MISO driven only as selected slave; select high floats it.
// - Enabled port owns MISO, MOSI and clock directions over port direction.
// - Master drives serial clock; slave takes it as input.
// - One byte each way in exactly eight serial clock cycles.
// - Master shifts out on MOSI while capturing MISO.
// - Slave select is always an input in slave role.
// - Slave with select high ignores every clock edge.
// - Master select level raises mode fault only with fault detect enabled.
// - Master select pin is port I/O without fault detect, input with it.
// - Select pin level stays readable through the shared port.
// - Control, status-control and data registers at indices 10, 11, 12.
// - Master with fault detect sets mode fault whenever select is low.
// - Slave phase zero starts on select fall and drives MSB at once.
`include "spi_port_map.svh"
`default_nettype none
module spi_port (
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire spi_port_pkg::byte_t   pwdata,
    output logic                       pready,
    output spi_port_pkg::byte_t        prdata,
    output logic                       pslverr,
    input  wire logic                  break_active,
    input  wire logic                  break_clear_enable,
    input  wire logic [2:0]            gp_out,
    input  wire logic [2:0]            gp_dir,
    output logic [2:0]                 pin_level,
    input  wire logic                  miso_in,
    output logic                       miso_out,
    output logic                       miso_oe_n,
    input  wire logic                  mosi_in,
    output logic                       mosi_out,
    output logic                       mosi_oe_n,
    input  wire logic                  serial_clock_pin_in,
    output logic                       serial_clock_pin_out,
    output logic                       serial_clock_pin_oe_n,
    input  wire logic                  ss_in,
    output logic                       ss_out,
    output logic                       ss_oe_n
);
    import spi_port_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'(`PORT_CONTROL_IDX * 4);
    localparam logic [7:0] ADDR_STAT = 8'(`PORT_STATUS_CONTROL_IDX * 4);
    localparam logic [7:0] ADDR_DATA = 8'(`PORT_DATA_IDX * 4);

    state_s q;
    state_s next_q;

    logic enabled;
    logic master;
    logic cpol;
    logic cpha;
    logic wom;
    logic fde;
    logic ss_lvl;
    logic clr_ok;
    logic acc;
    logic wr_ctrl;
    logic wr_data;
    logic rd_stat;
    logic rd_data;
    logic fault_now;
    logic slave_edge;
    logic lead;
    logic edge_go;
    logic capture;
    logic din;
    logic [4:0] half;

    assign enabled = q.ctrl[`CTL_MODULE_ENABLE];
    assign master  = q.ctrl[`CTL_MASTER_SELECT];
    assign cpol    = q.ctrl[`CTL_CPOL];
    assign cpha    = q.ctrl[`CTL_CPHA];
    assign wom     = q.ctrl[`CTL_WIRED_OR_MODE];
    assign fde     = q.stat[`ST_FAULT_DETECT_ENABLE];
    assign ss_lvl  = q.ss_sync[1];
    // Status bits may only be cleared outside break unless break clearing is allowed.
    assign clr_ok  = !break_active || break_clear_enable;
    assign acc     = psel && penable;
    assign wr_ctrl = acc && pwrite && (paddr == ADDR_CTRL);
    assign wr_data = acc && pwrite && (paddr == ADDR_DATA);
    assign rd_stat = acc && !pwrite && (paddr == ADDR_STAT);
    assign rd_data = acc && !pwrite && (paddr == ADDR_DATA);
    assign fault_now = enabled && master && fde && !ss_lvl;
    assign din = master ? q.miso_sync[1] : q.mosi_sync[1];
    // A select-high slave sees no edges at all, even mid-byte.
    assign slave_edge = !master && !ss_lvl && (q.sclk_sync[1] != q.sclk_sync[2]);
    assign lead = master ? !q.ecnt[0] : (q.sclk_sync[2] == cpol);
    assign capture = lead ^ cpha;

    always_comb begin
        case (q.stat[`ST_RATE_HI:`ST_RATE_LO])
            2'd0: half = `HALF_DIV0;
            2'd1: half = `HALF_DIV1;
            2'd2: half = `HALF_DIV2;
            default: half = `HALF_DIV3;
        endcase
    end

    always_comb begin
        edge_go = 1'b0;
        if (enabled && q.state == XFER_RUN) begin
            edge_go = master ? (q.div == 5'h00) : slave_edge;
        end else if (enabled && !master && cpha && slave_edge && lead) begin
            edge_go = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.sclk_sync = {q.sclk_sync[1:0], serial_clock_pin_in};
        next_q.ss_sync   = {q.ss_sync[1:0], ss_in};
        next_q.mosi_sync = {q.mosi_sync[0], mosi_in};
        next_q.miso_sync = {q.miso_sync[0], miso_in};
        next_q.pslverr   = 1'b0;
        if (psel && !penable) begin
            next_q.pslverr = !(paddr == ADDR_CTRL || paddr == ADDR_STAT || paddr == ADDR_DATA);
            case (paddr)
                ADDR_CTRL: next_q.prdata = q.ctrl;
                ADDR_STAT: next_q.prdata = q.stat;
                ADDR_DATA: next_q.prdata = q.rxbuf;
                default:   next_q.prdata = 8'h00;
            endcase
        end
        if (wr_ctrl) begin
            next_q.ctrl = pwdata;
        end
        if (acc && pwrite && paddr == ADDR_STAT) begin
            next_q.stat = (q.stat & ~`ST_WRITE_MASK) | (pwdata & `ST_WRITE_MASK);
        end
        // First step of the two-step clears; an arm taken before break survives it.
        if (rd_stat && clr_ok) begin
            if (q.stat[`ST_MODE_FAULT]) next_q.fault_arm = 1'b1;
            if (q.stat[`ST_OVERFLOW]) next_q.ovr_arm = 1'b1;
        end
        if (rd_data && clr_ok) begin
            next_q.stat[`ST_RX_FULL] = 1'b0;
            if (q.ovr_arm) begin
                next_q.stat[`ST_OVERFLOW] = 1'b0;
                next_q.ovr_arm = 1'b0;
            end
        end
        if (wr_data && clr_ok) begin
            next_q.txbuf = pwdata;
            next_q.txfull = 1'b1;
            next_q.stat[`ST_TX_EMPTY] = 1'b0;
            if (q.fault_arm && !fault_now) begin
                next_q.stat[`ST_MODE_FAULT] = 1'b0;
                next_q.fault_arm = 1'b0;
            end
        end
        if (!enabled) begin
            next_q.state = XFER_IDLE;
            next_q.txfull = 1'b0;
            next_q.stat[`ST_TX_EMPTY] = 1'b1;
            next_q.shreg = 8'h00;
            next_q.ecnt = 5'h00;
            next_q.sclk_out = cpol;
            next_q.dout = 1'b0;
        end else begin
            if (q.state == XFER_IDLE && q.txfull) begin
                next_q.shreg = q.txbuf;
                next_q.dout = q.txbuf[7];
                next_q.txfull = 1'b0;
                next_q.stat[`ST_TX_EMPTY] = 1'b1;
                if (master) begin
                    next_q.state = XFER_RUN;
                    next_q.ecnt = 5'h00;
                    next_q.div = half;
                    next_q.lead_cnt = 4'h0;
                end
            end
            if (!master && !cpha && q.ss_sync[2] && !ss_lvl) begin
                next_q.state = XFER_RUN;
                next_q.ecnt = 5'h00;
                next_q.dout = q.shreg[7];
                next_q.lead_cnt = 4'h0;
            end
            if (q.state == XFER_IDLE && edge_go) begin
                next_q.state = XFER_RUN;
                next_q.ecnt = 5'h00;
                next_q.lead_cnt = 4'h0;
            end
            if (master && q.state == XFER_RUN && q.div != 5'h00) begin
                next_q.div = q.div - 5'h01;
            end
            if (edge_go) begin
                if (master) begin
                    next_q.div = half;
                    next_q.sclk_out = !q.sclk_out;
                end
                if (lead) next_q.lead_cnt = next_q.lead_cnt + 4'h1;
                if (capture) begin
                    next_q.shreg = {q.shreg[6:0], din};
                end else begin
                    next_q.dout = q.shreg[7];
                end
                next_q.ecnt = q.ecnt + 5'h01;
                if (q.state == XFER_RUN && q.ecnt == `EDGE_LAST) begin
                    // Sixteen edges make eight clock cycles and one byte each way.
                    next_q.state = XFER_IDLE;
                    next_q.ecnt = 5'h00;
                    if (next_q.stat[`ST_RX_FULL]) begin
                        next_q.stat[`ST_OVERFLOW] = 1'b1;
                    end else begin
                        // Phase zero ends on a launch edge, so the byte is already whole in the shift register.
                        next_q.rxbuf = capture ? {q.shreg[6:0], din} : q.shreg;
                        next_q.stat[`ST_RX_FULL] = 1'b1;
                    end
                end
            end
            if (!master && q.state == XFER_RUN && ss_lvl && fde) begin
                next_q.stat[`ST_MODE_FAULT] = 1'b1;
            end
            // A master fault drops enable so the port stops fighting another master on its pins.
            if (fault_now) begin
                next_q.stat[`ST_MODE_FAULT] = 1'b1;
                next_q.ctrl[`CTL_MODULE_ENABLE] = 1'b0;
                next_q.state = XFER_IDLE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
            q.ctrl <= `CTL_RESET;
            q.stat <= `ST_RESET;
            q.sclk_sync <= 3'b000;
            q.ss_sync <= 3'b111;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Pins and bus outputs
    // ------------------------------------------------------------
    assign pready  = 1'b1;
    assign prdata  = q.prdata;
    assign pslverr = q.pslverr;
    assign pin_level = {q.ss_sync[1], q.sclk_sync[1], q.mosi_sync[1]};

    always_comb begin
        // Open drain drives only a low; a high is left to the pull-up.
        if (enabled && master) begin
            mosi_out  = wom ? 1'b0 : q.dout;
            mosi_oe_n = wom ? q.dout : 1'b0;
            serial_clock_pin_out  = wom ? 1'b0 : q.sclk_out;
            serial_clock_pin_oe_n = wom ? q.sclk_out : 1'b0;
        end else if (enabled) begin
            mosi_out  = 1'b0;
            mosi_oe_n = 1'b1;
            serial_clock_pin_out  = 1'b0;
            serial_clock_pin_oe_n = 1'b1;
        end else begin
            mosi_out  = gp_out[`PIN_MOSI];
            mosi_oe_n = !gp_dir[`PIN_MOSI];
            serial_clock_pin_out  = gp_out[`PIN_SCLK];
            serial_clock_pin_oe_n = !gp_dir[`PIN_SCLK];
        end
        if (enabled && !master && !ss_lvl) begin
            miso_out  = wom ? 1'b0 : q.dout;
            miso_oe_n = wom ? q.dout : 1'b0;
        end else begin
            miso_out  = 1'b0;
            miso_oe_n = 1'b1;
        end
        if (enabled && (!master || fde)) begin
            ss_out  = 1'b0;
            ss_oe_n = 1'b1;
        end else begin
            ss_out  = gp_out[`PIN_SS];
            ss_oe_n = !gp_dir[`PIN_SS];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_guarded_break;
        break_active && !break_clear_enable;
    endsequence
    sequence s_fault_seen;
        enabled && master && fde && !ss_lvl;
    endsequence
    sequence s_slave_select_fall;
        enabled && !master && !cpha && q.ss_sync[2] && !ss_lvl;
    endsequence

    chk_break_write_drop: assert property (s_guarded_break and wr_data |=> $stable(q.txbuf))
        else $error("data write taken during protected break");
    chk_break_flag_hold: assert property (s_guarded_break |=> !$fell(q.stat[`ST_RX_FULL])
        && !$fell(q.stat[`ST_MODE_FAULT]) && !$fell(q.stat[`ST_OVERFLOW]))
        else $error("status flag cleared during protected break");
    chk_break_clear_ok: assert property (break_active && break_clear_enable && rd_data
        |=> !q.stat[`ST_RX_FULL] || $past(q.state) == XFER_RUN)
        else $error("receive flag not cleared with break clearing enabled");
    chk_miso_float: assert property (!enabled || master || ss_lvl |-> miso_oe_n)
        else $error("miso driven while not a selected slave");
    chk_clock_dir: assert property (enabled && !master |-> serial_clock_pin_oe_n)
        else $error("slave drives the serial clock");
    chk_master_fault: assert property (s_fault_seen |=> q.stat[`ST_MODE_FAULT] && !enabled)
        else $error("master fault not raised");
    chk_fault_gate: assert property (master && !fde && !q.stat[`ST_MODE_FAULT] |=> !q.stat[`ST_MODE_FAULT])
        else $error("mode fault without fault detect");
    chk_eight_cycles: assert property (enabled && q.state == XFER_RUN && next_q.state == XFER_IDLE
        && edge_go |-> next_q.lead_cnt == 4'h8)
        else $error("transfer did not take eight clock cycles");
    chk_slave_ignore: assert property (enabled && !master && ss_lvl |-> !edge_go)
        else $error("slave used a clock edge while deselected");
    chk_slave_msb: assert property (s_slave_select_fall |=> q.state == XFER_RUN && q.dout == $past(q.shreg[7]))
        else $error("slave did not start on select fall");
    chk_select_port: assert property (!enabled |-> ss_oe_n == !gp_dir[`PIN_SS] && ss_out == gp_out[`PIN_SS])
        else $error("select pin not returned to port control");

endmodule
`default_nettype wire

//--- tb/spi_far_slave.sv
// Far-side serial slave model, clock phase 1 and idle-low clock.
`default_nettype none
module spi_far_slave (
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic [7:0]      rx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh;
    logic       bit_q;
    logic       drive;
    initial begin
        sh    = 8'h00;
        bit_q = 1'b0;
        drive = 1'b0;
        rx    = 8'h00;
    end
    always @(negedge sel_n) sh = tx;
    always @(posedge sel_n) drive = 1'b0;
    always @(posedge sclk) if (!sel_n) begin
        bit_q = sh[7];
        drive = 1'b1;
    end
    always @(negedge sclk) if (!sel_n) begin
        sh = {sh[6:0], mosi};
        rx = sh;
    end
    // A released line shows the inverse of its last bit, so stale data cannot pass.
    assign miso = drive ? bit_q : ~bit_q;
endmodule
`default_nettype wire

//--- tb/spi_port_test.sv
// Self-checking bench for the serial port block.
`include "spi_port_map.svh"
`default_nettype none
module spi_port_test;
    import spi_port_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] A_CTL  = 8'(`PORT_CONTROL_IDX * 4);
    localparam logic [7:0] A_ST   = 8'(`PORT_STATUS_CONTROL_IDX * 4);
    localparam logic [7:0] A_DATA = 8'(`PORT_DATA_IDX * 4);
    logic       clk_sys, srst, psel, penable, pwrite, pready, pslverr, brk, bce, err;
    logic       miso_out, miso_oe_n, mosi_out, mosi_oe_n, sclk_out, sclk_oe_n, ss_out, ss_oe_n;
    logic       ss_in, tb_sclk, tb_mosi, far_sel_n, prev, wor_on, wor_bad;
    logic [7:0] paddr, far_tx, far_rx, got;
    logic [2:0] gp_out, gp_dir, pin_level;
    byte_t      pwdata, prdata, rd;
    int         edges, fail_count, num_checks;
    wire logic  far_miso;
    wire logic  sclk_w = sclk_oe_n ? tb_sclk : sclk_out;
    wire logic  mosi_w = mosi_oe_n ? tb_mosi : mosi_out;
    wire logic  miso_w = miso_oe_n ? far_miso : miso_out;

    spi_port i_spi_port (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .break_active(brk), .break_clear_enable(bce), .gp_out(gp_out), .gp_dir(gp_dir),
        .pin_level(pin_level), .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
        .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .serial_clock_pin_in(sclk_w),
        .serial_clock_pin_out(sclk_out), .serial_clock_pin_oe_n(sclk_oe_n), .ss_in(ss_in),
        .ss_out(ss_out), .ss_oe_n(ss_oe_n));
    spi_far_slave i_spi_far_slave (.sclk(sclk_w), .mosi(mosi_w), .sel_n(far_sel_n), .tx(far_tx),
        .miso(far_miso), .rx(far_rx));

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        prev <= sclk_w;
        if (!sclk_oe_n && sclk_w !== prev) edges <= edges + 1;
        if (wor_on && !mosi_oe_n && mosi_out !== 1'b0) wor_bad <= 1'b1;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task apb(input logic wr, input logic [7:0] a, input byte_t d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_rx;
        rd = 8'h00;
        for (int n = 0; n < 200 && rd[`ST_RX_FULL] !== 1'b1; n++) apb(1'b0, A_ST, 8'h00);
        chk(rd[`ST_RX_FULL], 1'b1);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        apb(1'b0, A_CTL, 8'h00);
        chk(rd, `CTL_RESET);
        apb(1'b0, A_ST, 8'h00);
        chk(rd, `ST_RESET);
        apb(1'b1, 8'h4C, 8'hFF);
        chk(err, 1'b1);
        apb(1'b0, 8'h4C, 8'h00);
        chk({err, rd}, 9'h100);
        chk({mosi_oe_n, mosi_out, ss_oe_n, miso_oe_n}, 4'b0001);
    endtask
    task t_master;
        @(posedge clk_sys) gp_dir <= 3'b000;
        apb(1'b1, A_ST, 8'h02);
        apb(1'b1, A_CTL, 8'h2A);
        cyc(1);
        chk({mosi_oe_n, sclk_oe_n, sclk_w, ss_oe_n}, 4'b0001);
        @(posedge clk_sys) gp_dir <= 3'b100;
        cyc(2);
        chk({ss_oe_n, ss_out}, 2'b00);
        far_tx <= 8'h3C;
        far_sel_n <= 1'b0;
        edges <= 0;
        apb(1'b1, A_DATA, 8'hA5);
        wait_rx;
        chk(16'(edges), 16'h0010);
        chk(far_rx, 8'hA5);
        apb(1'b0, A_DATA, 8'h00);
        chk(rd, 8'h3C);
        far_sel_n <= 1'b1;
        tb_sclk <= 1'b1;
        apb(1'b1, A_CTL, 8'h2E);
        far_sel_n <= 1'b0;
        wor_on <= 1'b1;
        apb(1'b1, A_DATA, 8'h96);
        wait_rx;
        chk({wor_bad, far_rx}, 9'h096);
        apb(1'b0, A_DATA, 8'h00);
        wor_on <= 1'b0;
        far_sel_n <= 1'b1;
        tb_sclk <= 1'b0;
    endtask
    task t_fault;
        apb(1'b1, A_CTL, 8'h2A);
        apb(1'b1, A_ST, 8'h06);
        cyc(1);
        chk(ss_oe_n, 1'b1);
        @(posedge clk_sys) ss_in <= 1'b0;
        cyc(6);
        chk(pin_level[`PIN_SS], 1'b0);
        apb(1'b0, A_ST, 8'h00);
        chk(rd[`ST_MODE_FAULT], 1'b1);
        apb(1'b0, A_CTL, 8'h00);
        chk(rd[`CTL_MODULE_ENABLE], 1'b0);
        ss_in <= 1'b1;
        cyc(6);
        apb(1'b0, A_ST, 8'h00);
        brk <= 1'b1;
        apb(1'b1, A_DATA, 8'h55);
        apb(1'b0, A_ST, 8'h00);
        chk(rd & 8'h18, 8'h18);
        brk <= 1'b0;
        apb(1'b1, A_DATA, 8'h55);
        apb(1'b0, A_ST, 8'h00);
        chk(rd[`ST_MODE_FAULT], 1'b0);
        apb(1'b1, A_ST, 8'h02);
        apb(1'b1, A_CTL, 8'h2A);
        ss_in <= 1'b0;
        cyc(6);
        apb(1'b0, A_ST, 8'h00);
        chk(rd[`ST_MODE_FAULT], 1'b0);
        apb(1'b1, A_ST, 8'h06);
        cyc(6);
        ss_in <= 1'b1;
        cyc(6);
        brk <= 1'b1;
        bce <= 1'b1;
        apb(1'b0, A_ST, 8'h00);
        chk(rd[`ST_MODE_FAULT], 1'b1);
        apb(1'b1, A_DATA, 8'h00);
        apb(1'b0, A_ST, 8'h00);
        chk(rd[`ST_MODE_FAULT], 1'b0);
        apb(1'b0, A_DATA, 8'h00);
        brk <= 1'b0;
        bce <= 1'b0;
        apb(1'b0, A_ST, 8'h00);
        chk(rd[`ST_MODE_FAULT], 1'b0);
    endtask
    task t_slave;
        apb(1'b1, A_ST, 8'h02);
        apb(1'b1, A_CTL, 8'h02);
        apb(1'b1, A_DATA, 8'h81);
        chk({ss_oe_n, miso_oe_n, sclk_oe_n}, 3'b111);
        repeat (3) begin
            #62.5 tb_sclk = 1'b1;
            #62.5 tb_sclk = 1'b0;
        end
        @(posedge clk_sys) ss_in <= 1'b0;
        cyc(8);
        chk({miso_oe_n, miso_w}, 2'b01);
        for (int i = 7; i >= 0; i--) begin
            tb_mosi = i[0] ^ i[1] ^ (i < 4);
            #62.5 tb_sclk = 1'b1;
            got[i] = miso_w;
            #62.5 tb_sclk = 0;
        end
        cyc(8);
        chk(got, 8'h81);
        @(posedge clk_sys) ss_in <= 1'b1;
        tb_mosi = 1'b1;
        cyc(6);
        chk(miso_oe_n, 1'b1);
        apb(1'b0, A_DATA, 8'h00);
        chk(rd, 8'h69);
    endtask

    initial begin
        {clk_sys, psel, penable, pwrite, brk, bce, tb_sclk, prev, wor_on, wor_bad} = '0;
        {srst, ss_in, tb_mosi, far_sel_n} = 4'hF;
        {paddr, pwdata, far_tx, got} = '0;
        gp_out = 3'b010;
        gp_dir = 3'b101;
        {edges, fail_count, num_checks} = '0;
        cyc(16);
        srst <= 1'b0;
        t_reset;
        t_master;
        t_fault;
        t_slave;
        print_verdict;
    end
    initial begin
        #200000;
        fail_count++;
        print_verdict;
    end
endmodule
`default_nettype wire
